// >>> design/ocrs_core.sv
// Output clock divider with resync hold, release counting and realignment
module ocrs_core (
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   input  wire logic             clk_en_in,
   input  wire ocrs_pkg::ocrs_cfg_t cfg_in,
   input  wire logic             output_clock_resync_in,
   output ocrs_pkg::ocrs_clk_t   out_clocks_out,
   output logic                  resync_busy_out,
   output logic                  resync_seen_out
);
   // ----------------------------------------
   // Synchroniser and release detect
   // ----------------------------------------
   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;
   logic armed;
   logic release_pulse;

   assign armed = cfg_in.extended_control_mode & cfg_in.resync_enable;

   // Any arrival phase is fine: double flop before use
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end else if (clk_en_in) begin
         sync1_reg <= output_clock_resync_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign release_pulse = sync3_reg & ~sync2_reg;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   ocrs_pkg::ocrs_state_t state_reg;
   ocrs_pkg::ocrs_state_t state_next;
   logic [2:0]            cnt_reg;
   logic [2:0]            cnt_next;
   logic [2:0]            load_val;

   // Sync latency already spent counts against the documented figure
   always_comb begin
      if (cfg_in.output_phase_select) begin
         load_val = ocrs_pkg::OCRS_DLY_90 - ocrs_pkg::OCRS_SYNC_LAT;
      end else begin
         load_val = ocrs_pkg::OCRS_DLY_0 - ocrs_pkg::OCRS_SYNC_LAT;
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ocrs_pkg::OCRS_IDLE: begin
            if (armed && sync2_reg) begin
               state_next = ocrs_pkg::OCRS_HOLD;
            end
         end
         ocrs_pkg::OCRS_HOLD: begin
            if (release_pulse) begin
               state_next = ocrs_pkg::OCRS_COUNT;
               cnt_next   = load_val;
            end
         end
         ocrs_pkg::OCRS_COUNT: begin
            if (sync2_reg) begin
               state_next = ocrs_pkg::OCRS_HOLD;
            end else if (cnt_reg == 3'h1) begin
               state_next = ocrs_pkg::OCRS_RESTART;
               cnt_next   = ocrs_pkg::OCRS_RESTART_DLY;
            end else begin
               cnt_next = cnt_reg - 3'h1;
            end
         end
         ocrs_pkg::OCRS_RESTART: begin
            if (sync2_reg) begin
               state_next = ocrs_pkg::OCRS_HOLD;
            end else if (cnt_reg == 3'h1) begin
               state_next = ocrs_pkg::OCRS_IDLE;
            end else begin
               cnt_next = cnt_reg - 3'h1;
            end
         end
         default: begin
            state_next = ocrs_pkg::OCRS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_reg <= ocrs_pkg::OCRS_IDLE;
         cnt_reg   <= 3'h0;
      end else if (clk_en_in) begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ----------------------------------------
   // Output clock: divide-by-four in demux mode, divide-by-two otherwise
   // ----------------------------------------
   logic [1:0] div_reg;
   logic       align;
   logic       hold_hi;
   logic       seen_reg;

   assign align   = (state_reg == ocrs_pkg::OCRS_COUNT) && (cnt_reg == 3'h1) && !sync2_reg;
   assign hold_hi = cfg_in.demux_mode && (state_reg != ocrs_pkg::OCRS_IDLE);

   // Phase counter realigns to a known state on the aligning edge
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         div_reg <= ocrs_pkg::OCRS_DIV_RST;
      end else if (clk_en_in) begin
         if (align) begin
            div_reg <= ocrs_pkg::OCRS_DIV_RST;
         end else begin
            div_reg <= div_reg + 2'h1;
         end
      end
   end

   // Non-demux mode keeps toggling through hold; only realignment or reset may repeat one level
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         out_clocks_out <= '0;
      end else if (clk_en_in) begin
         if (hold_hi) begin
            out_clocks_out.i_channel_out_clock <= 1'b1;
            out_clocks_out.q_channel_out_clock <= 1'b1;
         end else if (cfg_in.demux_mode) begin
            out_clocks_out.i_channel_out_clock <= div_reg < ocrs_pkg::OCRS_DIV_HALF;
            out_clocks_out.q_channel_out_clock <= div_reg < ocrs_pkg::OCRS_DIV_HALF;
         end else begin
            out_clocks_out.i_channel_out_clock <= div_reg[0];
            out_clocks_out.q_channel_out_clock <= div_reg[0];
         end
      end
   end

   // Flag is low until the first alignment after reset, then stays set
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         seen_reg <= 1'b0;
      end else if (clk_en_in && align) begin
         seen_reg <= 1'b1;
      end
   end

   assign resync_busy_out = state_reg != ocrs_pkg::OCRS_IDLE;
   assign resync_seen_out = seen_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_iq_aligned: assert property (@(posedge clk_in) disable iff (srst_in)
      out_clocks_out.i_channel_out_clock == out_clocks_out.q_channel_out_clock)
      else $error("I and Q clocks differ");

   a_disabled_idle: assert property (@(posedge clk_in) disable iff (srst_in)
      !armed && state_reg == ocrs_pkg::OCRS_IDLE && clk_en_in
      |=> state_reg == ocrs_pkg::OCRS_IDLE)
      else $error("Resync ran while disabled");

   a_demux_hold: assert property (@(posedge clk_in) disable iff (srst_in)
      clk_en_in && cfg_in.demux_mode && state_reg == ocrs_pkg::OCRS_HOLD
      |=> out_clocks_out.i_channel_out_clock)
      else $error("Clock not held high");

   // Realign and reset restart the phase counter, so one level may repeat there
   a_nondemux_run: assert property (@(posedge clk_in) disable iff (srst_in)
      clk_en_in && !cfg_in.demux_mode && $past(clk_en_in) && $past(!cfg_in.demux_mode)
      && $past(!align) && $past(!srst_in)
      |=> out_clocks_out.i_channel_out_clock != $past(out_clocks_out.i_channel_out_clock))
      else $error("Non-demux clock stopped");

   a_align_90: assert property (@(posedge clk_in) disable iff (srst_in)
      release_pulse && state_reg == ocrs_pkg::OCRS_HOLD && cfg_in.output_phase_select
      && clk_en_in ##1 (clk_en_in && !sync2_reg) [*2] |-> align)
      else $error("90 degree alignment late");

   a_align_0: assert property (@(posedge clk_in) disable iff (srst_in)
      release_pulse && state_reg == ocrs_pkg::OCRS_HOLD && !cfg_in.output_phase_select
      && clk_en_in ##1 (clk_en_in && !sync2_reg) [*3] |-> align)
      else $error("0 degree alignment late");

   a_restart_seq: assert property (@(posedge clk_in) disable iff (srst_in)
      align && clk_en_in |=> state_reg == ocrs_pkg::OCRS_RESTART)
      else $error("Restart not entered");

   a_align_phase: assert property (@(posedge clk_in) disable iff (srst_in)
      align && clk_en_in |=> div_reg == ocrs_pkg::OCRS_DIV_RST)
      else $error("Divider not realigned");

   a_hold_entry: assert property (@(posedge clk_in) disable iff (srst_in)
      clk_en_in && armed && sync2_reg && state_reg == ocrs_pkg::OCRS_IDLE
      |=> state_reg == ocrs_pkg::OCRS_HOLD)
      else $error("Hold not entered");

   a_release_count: assert property (@(posedge clk_in) disable iff (srst_in)
      clk_en_in && release_pulse && state_reg == ocrs_pkg::OCRS_HOLD
      |=> state_reg == ocrs_pkg::OCRS_COUNT)
      else $error("Count not started");

   a_count_down: assert property (@(posedge clk_in) disable iff (srst_in)
      clk_en_in && state_reg == ocrs_pkg::OCRS_COUNT && !sync2_reg && cnt_reg != 3'h1
      |=> cnt_reg == $past(cnt_reg) - 3'h1)
      else $error("Counter did not step");

   a_restart_idle: assert property (@(posedge clk_in) disable iff (srst_in)
      clk_en_in && state_reg == ocrs_pkg::OCRS_RESTART && !sync2_reg && cnt_reg == 3'h1
      |=> state_reg == ocrs_pkg::OCRS_IDLE)
      else $error("Restart did not end");

   a_seen_set: assert property (@(posedge clk_in) disable iff (srst_in)
      align && clk_en_in |=> resync_seen_out)
      else $error("Alignment not flagged");
endmodule

// >>> design/ocrs_pkg.sv
// Constants and carrier types for the output clock resync block
package ocrs_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam logic [2:0] OCRS_DLY_90      = 3'h4;
   localparam logic [2:0] OCRS_DLY_0       = 3'h5;
   // Release edge reaches the counter two flops late
   localparam logic [2:0] OCRS_SYNC_LAT    = 3'h2;
   localparam logic [2:0] OCRS_RESTART_DLY = 3'h2;
   localparam logic [1:0] OCRS_DIV_RST     = 2'h0;
   localparam logic [1:0] OCRS_DIV_HALF    = 2'h2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      OCRS_IDLE    = 4'h1,
      OCRS_HOLD    = 4'h2,
      OCRS_COUNT   = 4'h4,
      OCRS_RESTART = 4'h8
   } ocrs_state_t;

   typedef struct packed {
      logic extended_control_mode;
      logic resync_enable;
      logic demux_mode;
      logic output_phase_select;
   } ocrs_cfg_t;

   typedef struct packed {
      logic i_channel_out_clock;
      logic q_channel_out_clock;
   } ocrs_clk_t;
endpackage

// >>> sim/ocrs_ctrl_model.sv
// Controller model that drives the resync pulse
module ocrs_ctrl_model (
   input  wire logic       clk_in,
   input  wire logic       fire_in,
   input  wire logic [7:0] width_in,
   output logic            resync_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] left_reg = 8'h00;

   initial resync_out = 1'b0;

   // Start a pulse of width_in sample cycles on request
   always @(posedge clk_in) begin
      if (fire_in && left_reg == 8'h00)
         left_reg <= width_in;
      else if (left_reg != 8'h00)
         left_reg <= left_reg - 8'h01;
   end

   // Edges land 13 ns after each sample clock rising edge, between clock edges
   always @(posedge clk_in) begin
      #13 resync_out = (left_reg != 8'h00);
   end
endmodule

// >>> sim/ocrs_core_tb.sv
// Testbench for the output clock resync core
module ocrs_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                clk = 1'b0;
   logic                srst = 1'b1;
   logic                en = 1'b1;
   logic                fire = 1'b0;
   logic [7:0]          width = 8'h0c;
   logic [7:0]          v;
   logic [7:0]          w;
   ocrs_pkg::ocrs_cfg_t cfg = 4'h0;
   ocrs_pkg::ocrs_clk_t ck;
   logic                rs, busy, seen;
   int                  error_cnt = 0, num_checks = 0, n, n90, k;

   always #20 clk = ~clk;

   ocrs_ctrl_model ctrl_u (.clk_in(clk), .fire_in(fire), .width_in(width),
      .resync_out(rs));
   ocrs_core dut_u (.clk_in(clk), .srst_in(srst), .clk_en_in(en), .cfg_in(cfg),
      .output_clock_resync_in(rs), .out_clocks_out(ck), .resync_busy_out(busy),
      .resync_seen_out(seen));

   // --------
   // Helpers
   // --------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (error_cnt == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Leaves the pulse still high, hold well established
   task pulse;
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask
   // Cycles from first edge after release until idle
   task finish(output int c);
      while (rs === 1'b1) begin @(posedge clk); #1; end
      c = 0;
      while (busy !== 1'b0 && c < 50) begin @(posedge clk); #1; c++; end
   endtask
   task sample;
      v = 8'h00;
      repeat (8) begin @(posedge clk); #1; v = {v[6:0], ck[1]}; end
   endtask

   always @(negedge clk) if (!srst) chk(ck[1], ck[0]);

   initial begin
      #400000;
      error_cnt++;
      test_done();
   end

   // --------
   // Tests
   // --------
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1 chk(ck, 2'h0);
      @(posedge clk); #1;
      chk({busy, seen}, 2'h0);
      for (k = 0; k < 2; k++) begin
         @(posedge clk) cfg <= k ? 4'hb : 4'h7;
         pulse();
         chk(busy, 1'b0);
         finish(n);
      end
      @(posedge clk) cfg <= 4'hf; // Same phase select kept for every run except the 0 degree run
      pulse(); // Throwaway pulse first
      finish(n);
      pulse();
      chk(ck, 2'h3);
      chk(busy, 1'b1);
      finish(n90);
      chk(seen, 1'b1);
      sample();
      w = v;
      chk(v, {v[3:0], v[3:0]});
      chk({v[0] ^ v[2], v[1] ^ v[3]}, 2'h3);
      pulse();
      finish(n);
      sample();
      chk(v, w);
      chk(8'(n), 8'(n90));
      @(posedge clk) cfg <= 4'he;
      pulse();
      finish(n);
      chk(8'(n), 8'(n90 + 1));
      @(posedge clk) cfg <= 4'hf;
      pulse();
      while (rs === 1'b1) begin @(posedge clk); #1; end
      repeat (3) begin @(posedge clk); #1; chk(busy, 1'b1); end
      pulse();
      chk(ck, 2'h3);
      finish(n);
      chk(8'(n), 8'(n90));
      @(posedge clk) cfg <= 4'hd;
      pulse();
      sample();
      chk({v[0] ^ v[1], v[4] ^ v[5]}, 2'h3);
      finish(n);
      @(posedge clk) en <= 1'b0;
      @(posedge clk); #1;
      w = ck;
      repeat (4) @(posedge clk);
      #1 chk(ck, w);
      en <= 1'b1;
      test_done();
   end
endmodule
